// File: dv/twsp_i2c_master.sv
// Bus master model for the two-wire slave port bench.
// Assumes both lines are resolved as wired-AND with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module twsp_i2c_master (
	// Pull-downs
	output logic     sclLow,
	output logic     sdaLow,
	// Resolved lines
	input wire logic scl,
	input wire logic sda
);
	////////////////////////////////////////
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// Data moves 10 ns after the fall, so no false START or STOP
	task automatic bitXfer(input logic b, output logic r);
		#10;
		sdaLow = !b;
		#30;
		sclLow = 1'b0;
		wait (scl);
		#40;
		r = sda;
		sclLow = 1'b1;
	endtask : bitXfer
	task automatic startCond();
		#10;
		sdaLow = 1'b0;
		#30;
		sclLow = 1'b0;
		wait (scl);
		#40;
		sdaLow = 1'b1;
		#40;
		sclLow = 1'b1;
	endtask : startCond
	task automatic stopCond();
		#10;
		sdaLow = 1'b1;
		#30;
		sclLow = 1'b0;
		wait (scl);
		#40;
		sdaLow = 1'b0;
		#40;
	endtask : stopCond
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitXfer(d[i], r);
		bitXfer(1'b1, r);
		ack = !r;
	endtask : sendByte
	task automatic recvByte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitXfer(1'b1, r);
			d[i] = r;
		end
		bitXfer(nack, r);
	endtask : recvByte
endmodule : twsp_i2c_master
`default_nettype wire

// File: dv/twsp_port_checker.sv
// Port-level relations of the two-wire slave port.
// Assumes it is bound to twsp_slave_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module twsp_port_checker (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Software side
	input wire logic       portEnable,
	input wire logic [3:0] modeSelect,
	input wire logic       bufferRead,
	input wire logic       ownAddressWrite,
	input wire logic       irqFlagClear,
	input wire logic       irqEnable,
	input wire logic [7:0] transferBuffer,
	input wire logic       bufferFull,
	input wire logic       portIrqFlag,
	input wire logic       portIrq,
	input wire logic       addressUpdateNeeded,
	input wire logic       readWriteStatus,
	input wire logic       clockRelease,
	// Bus pins
	input wire logic       busClk,
	input wire logic       busDataIn,
	input wire logic       busClkOutEn,
	input wire logic       busDataOutEn
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Link events land 2-3 cycles late; clears are judged on a quiet bus
	logic [3:0] quietCnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			quietCnt <= 4'h0;
		else if ($changed(busClk) || $changed(busDataIn))
			quietCnt <= 4'h0;
		else if (quietCnt != 4'hf)
			quietCnt <= quietCnt + 4'h1;
	end
	wire logic settled = quietCnt > 4'h5;
	////////////////////////////////////////
	AST_PINS_OFF: assert property (!portEnable |-> !busClkOutEn && !busDataOutEn)
		else $error("pins driven while port off");
	AST_MASTER_IDLE: assert property (modeSelect == twsp_pkg::MODE_FW_MASTER |-> !busClkOutEn && !busDataOutEn)
		else $error("pins driven in master mode");
	AST_HOLD_CLEAR: assert property (portEnable && !clockRelease |-> busClkOutEn)
		else $error("clock not held");
	AST_TX_EDGE: assert property (portEnable && $past(portEnable) && $changed(busDataOutEn) |-> !busClk)
		else $error("data changed while clock high");
	AST_READ_CLEARS: assert property (bufferRead && settled |=> !bufferFull)
		else $error("full not cleared by read");
	AST_ADDR_WRITE: assert property (ownAddressWrite && settled |=> !addressUpdateNeeded)
		else $error("update flag not cleared");
	AST_IRQ_CLEAR: assert property (irqFlagClear && settled |=> !portIrqFlag)
		else $error("flag not cleared");
	AST_IRQ_GATE: assert property (portIrq == (portIrqFlag && irqEnable))
		else $error("irq not gated by enable");
	AST_RW_ADDR: assert property ($rose(readWriteStatus) |-> ##[0:2] (bufferFull && transferBuffer[0]))
		else $error("read address not buffered");
endmodule : twsp_port_checker
bind twsp_slave_port twsp_port_checker chk_u (.ref_clk, .rst_n, .portEnable,
	.modeSelect, .bufferRead, .ownAddressWrite, .irqFlagClear, .irqEnable,
	.transferBuffer, .bufferFull, .portIrqFlag, .portIrq, .addressUpdateNeeded,
	.readWriteStatus, .clockRelease, .busClk, .busDataIn, .busClkOutEn,
	.busDataOutEn);
`default_nettype wire

// File: dv/twsp_slave_port_bench.sv
// Bench for the two-wire slave port: software strobes plus a bus master.
// Assumes pull-ups on both lines and the master model in the same run.
`timescale 1ns/100ps
`default_nettype none
module twsp_slave_port_bench;
	logic ref_clk = 1'b0, rst_n = 1'b0, portEnable = 1'b0, irqEnable = 1'b0;
	logic [3:0] modeSelect = twsp_pkg::MODE_SLAVE7;
	logic bufferRead = 1'b0, bufferWrite = 1'b0, ownAddressWrite = 1'b0;
	logic clockReleaseWrite = 1'b0, clockReleaseData = 1'b0;
	logic overflowClear = 1'b0, irqFlagClear = 1'b0;
	logic [7:0] bufferWriteData = 8'h00, ownAddressData = 8'h00;
	logic [7:0] transferBuffer, dat, got;
	logic bufferFull, receiveOverflow, portIrqFlag, portIrq, ack;
	logic addressUpdateNeeded, readWriteStatus, clockRelease;
	logic busClkOutEn, busDataOutEn, mSclLow, mSdaLow;
	logic startDetected, stopDetected;
	logic [1:0] pinDir = 2'b11;
	wire logic busClk = !(busClkOutEn || mSclLow);
	wire logic busDataIn = !(busDataOutEn || mSdaLow);
	int num_errors = 0, tests_run = 0, cycles = 0;
	logic [6:0] addr;
	logic [9:0] addr10;
	logic [19:0] modeList = {twsp_pkg::MODE_SLAVE7, twsp_pkg::MODE_SLAVE10,
		twsp_pkg::MODE_FW_MASTER, twsp_pkg::MODE_SLAVE7_SS,
		twsp_pkg::MODE_SLAVE10_SS};
	twsp_slave_port dut_u (.ref_clk, .rst_n, .portEnable, .modeSelect,
		.pinDirectionC(pinDir), .irqEnable, .bufferRead, .bufferWrite,
		.bufferWriteData, .ownAddressWrite, .ownAddressData, .clockReleaseWrite,
		.clockReleaseData, .overflowClear, .irqFlagClear, .transferBuffer,
		.bufferFull, .receiveOverflow, .portIrqFlag, .portIrq,
		.addressUpdateNeeded, .readWriteStatus, .clockRelease, .startDetected,
		.stopDetected, .busClk, .busClkOut(), .busClkOutEn, .busDataIn,
		.busDataOut(), .busDataOutEn);
	twsp_i2c_master mst_u (.sclLow(mSclLow), .sdaLow(mSdaLow), .scl(busClk),
		.sda(busDataIn));
	////////////////////////////////////////
	always #12.5 ref_clk = !ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [7:0] st(input logic f, o, w, u, i, c);
		return {2'b00, f, o, w, u, i, c};
	endfunction : st
	function automatic logic [7:0] stat();
		return st(bufferFull, receiveOverflow, readWriteStatus,
			addressUpdateNeeded, portIrqFlag, clockRelease);
	endfunction : stat
	// One-cycle software strobe: 0 read, 1 write, 2 address, 3 release,
	// 4 overflow clear, 5 flag clear
	task automatic sw(input int op, input logic [7:0] d);
		@(posedge ref_clk);
		#2;
		case (op)
			0: bufferRead = 1'b1;
			1: bufferWrite = 1'b1;
			2: ownAddressWrite = 1'b1;
			3: clockReleaseWrite = 1'b1;
			4: overflowClear = 1'b1;
			default: irqFlagClear = 1'b1;
		endcase
		{bufferWriteData, ownAddressData, clockReleaseData} = {d, d, d[0]};
		@(posedge ref_clk);
		#2;
		{bufferRead, bufferWrite, ownAddressWrite} = 3'h0;
		{clockReleaseWrite, overflowClear, irqFlagClear} = 3'h0;
	endtask : sw
	task automatic settle();
		repeat (8) @(posedge ref_clk);
		#2;
	endtask : settle
	task automatic clr();
		settle();
		sw(0, 8'h00);
		sw(5, 8'h00);
	endtask : clr
	task automatic put(input logic [7:0] d, input logic e);
		mst_u.sendByte(d, ack);
		chk({7'h0, ack}, {7'h0, e});
		settle();
	endtask : put
	// Feed n bytes to a reading master; it acks all but the last
	task automatic serve(input int n);
		for (int k = 0; k < n; k++) begin
			dat = 8'($urandom);
			sw(0, 8'h00);
			sw(5, 8'h00);
			sw(1, dat);
			chk(stat(), st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
			sw(3, 8'h01);
			mst_u.recvByte(k == n - 1, got);
			chk(got, dat);
			settle();
			chk(stat(), st(1'b0, 1'b0, k < n - 1, 1'b0, 1'b1, k == n - 1));
		end
	endtask : serve
	////////////////////////////////////////
	initial begin
		addr = 7'h08 + 7'($urandom(32'h0b157aa8) % 96);
		repeat (4) @(posedge ref_clk);
		#2;
		rst_n = 1'b1;
		chk(stat(), st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
		for (int i = 4; i >= 0; i--) begin
			modeSelect = modeList[i*4 +: 4];
			portEnable = i != 0;
			sw(2, {addr, 1'b0});
			mst_u.startCond();
			put({addr, 1'b0}, i == 1 || i == 4);
			mst_u.stopCond();
			clr();
		end
		modeSelect = twsp_pkg::MODE_SLAVE7;
		portEnable = 1'b1;
		pinDir = 2'b01;
		sw(2, {addr, 1'b0});
		mst_u.startCond();
		put({addr, 1'b0}, 1'b0);
		mst_u.stopCond();
		clr();
		pinDir = 2'b11;
		sw(2, 8'h00);
		mst_u.startCond();
		put(8'h00, 1'b0);
		mst_u.stopCond();
		sw(2, {addr, 1'b0});
		mst_u.startCond();
		put({addr ^ 7'h01, 1'b0}, 1'b0);
		chk(stat(), st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
		mst_u.stopCond();
		settle();
		chk({6'h0, startDetected, stopDetected}, 8'h01);
		irqEnable = 1'b1;
		mst_u.startCond();
		put({addr, 1'b0}, 1'b1);
		chk(transferBuffer, {addr, 1'b0});
		chk(stat(), st(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
		chk({7'h0, portIrq}, 8'h01);
		sw(5, 8'h00);
		dat = 8'($urandom);
		put(dat, 1'b0);
		chk(transferBuffer, {addr, 1'b0});
		chk(stat(), st(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
		clr();
		chk(stat(), st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
		irqEnable = 1'b0;
		put(dat, 1'b0);
		chk(transferBuffer, dat);
		chk({6'h0, portIrqFlag, portIrq}, 8'h02);
		sw(4, 8'h00);
		clr();
		put(~dat, 1'b1);
		chk(transferBuffer, ~dat);
		mst_u.stopCond();
		clr();
		mst_u.startCond();
		put({addr, 1'b1}, 1'b1);
		chk(stat(), st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
		chk({7'h0, busClkOutEn}, 8'h01);
		chk({6'h0, startDetected, stopDetected}, 8'h02);
		serve(2);
		mst_u.stopCond();
		modeSelect = twsp_pkg::MODE_SLAVE10;
		addr10 = 10'($urandom);
		dat = {twsp_pkg::TEN_BIT_PREFIX, addr10[9:8], 1'b0};
		sw(2, dat);
		mst_u.startCond();
		put(dat, 1'b1);
		chk(stat(), st(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
		sw(2, addr10[7:0]);
		clr();
		chk(stat(), st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
		put(addr10[7:0], 1'b1);
		chk(stat(), st(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
		sw(2, dat);
		clr();
		mst_u.startCond();
		put(dat | 8'h01, 1'b1);
		chk(stat(), st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
		serve(1);
		mst_u.stopCond();
		end_of_test();
	end
endmodule : twsp_slave_port_bench
`default_nettype wire

// File: rtl/twsp_pkg.sv
// Constants, mode codes and phase type for the two-wire slave port.
// Assumes every user names each item as twsp_pkg::name.
package twsp_pkg;

	// Mode select encodings
	localparam logic [3:0] MODE_SLAVE7       = 4'h6;
	localparam logic [3:0] MODE_SLAVE10      = 4'h7;
	localparam logic [3:0] MODE_FW_MASTER    = 4'hb;
	localparam logic [3:0] MODE_SLAVE7_SS    = 4'he;
	localparam logic [3:0] MODE_SLAVE10_SS   = 4'hf;

	// Bit counter positions within one nine-clock byte slot
	localparam logic [3:0] BIT_IDLE          = 4'h0;
	localparam logic [3:0] BIT_FIRST         = 4'h1;
	localparam logic [3:0] BIT_LAST_DATA     = 4'h8;
	localparam logic [3:0] BIT_ACK           = 4'h9;
	localparam logic [3:0] BIT_STEP          = 4'h1;

	// Address patterns
	localparam logic [4:0] TEN_BIT_PREFIX    = 5'h1e;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

	// Transmit bit index of the first bit sent
	localparam logic [2:0] TX_MSB            = 3'h7;

	// Pin direction field positions (set lets the port drive the pin low)
	localparam int         DIR_CLK           = 0;
	localparam int         DIR_DATA          = 1;

	// Reset values
	localparam logic [7:0] BUFFER_RESET      = 8'h00;
	localparam logic [7:0] OWN_ADDR_RESET    = 8'h00;
	localparam logic       CLK_RELEASE_RESET = 1'b1;

	// One-hot link phase after the address byte
	typedef enum logic [3:0] {
		PH_IDLE  = 4'h1,
		PH_ADDR2 = 4'h2,
		PH_RECV  = 4'h4,
		PH_XMIT  = 4'h8
	} twsp_phase_e;

endpackage : twsp_pkg

// File: rtl/twsp_slave_port.sv
// Two-wire slave port: address match, receive, transmit, clock stretch.
// Assumes busClk is the raw bus clock pin and busDataIn the raw data pin;
// software drives the control pulses synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module twsp_slave_port (
	// Core clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Software control
	input  wire logic       portEnable,
	input  wire logic [3:0] modeSelect,
	input  wire logic [1:0] pinDirectionC,
	input  wire logic       irqEnable,
	input  wire logic       bufferRead,
	input  wire logic       bufferWrite,
	input  wire logic [7:0] bufferWriteData,
	input  wire logic       ownAddressWrite,
	input  wire logic [7:0] ownAddressData,
	input  wire logic       clockReleaseWrite,
	input  wire logic       clockReleaseData,
	input  wire logic       overflowClear,
	input  wire logic       irqFlagClear,
	// Software status
	output logic      [7:0] transferBuffer,
	output logic            bufferFull,
	output logic            receiveOverflow,
	output logic            portIrqFlag,
	output logic            portIrq,
	output logic            addressUpdateNeeded,
	output logic            readWriteStatus,
	output logic            clockRelease,
	output logic            startDetected,
	output logic            stopDetected,
	// Bus pins
	input  wire logic       busClk,
	output logic            busClkOut,
	output logic            busClkOutEn,
	input  wire logic       busDataIn,
	output logic            busDataOut,
	output logic            busDataOutEn
);

	////////////////////////////////////////////////////////////////////////
	// Mode decode and link-facing configuration

	logic       slave7;
	logic       slave10;
	logic       twoWire;
	logic       ssIrqMode;
	logic [3:0] linkCfg_reg;
	logic [3:0] linkCfgMeta_reg;
	logic [3:0] linkCfgSync_reg;

	assign slave7    = portEnable &&
		(modeSelect == twsp_pkg::MODE_SLAVE7 ||
		 modeSelect == twsp_pkg::MODE_SLAVE7_SS);
	assign slave10   = portEnable &&
		(modeSelect == twsp_pkg::MODE_SLAVE10 ||
		 modeSelect == twsp_pkg::MODE_SLAVE10_SS);
	assign ssIrqMode = portEnable &&
		(modeSelect == twsp_pkg::MODE_SLAVE7_SS ||
		 modeSelect == twsp_pkg::MODE_SLAVE10_SS);
	assign twoWire   = portEnable && (slave7 || slave10 ||
		modeSelect == twsp_pkg::MODE_FW_MASTER);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			linkCfg_reg <= 4'h0;
		else
			linkCfg_reg <= {slave7, slave10, bufferFull, receiveOverflow};
	end

	// Each bit is an independent level, so a two-stage sync per bit is safe
	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			linkCfgMeta_reg <= 4'h0;
			linkCfgSync_reg <= 4'h0;
		end else begin
			linkCfgMeta_reg <= linkCfg_reg;
			linkCfgSync_reg <= linkCfgMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// START and STOP detection, clocked by the data pin itself

	logic startTog_reg;
	logic stopTog_reg;

	always_ff @(negedge busDataIn or negedge rst_n) begin
		if (!rst_n)
			startTog_reg <= 1'b0;
		else if (busClk)
			startTog_reg <= ~startTog_reg;
	end

	always_ff @(posedge busDataIn or negedge rst_n) begin
		if (!rst_n)
			stopTog_reg <= 1'b0;
		else if (busClk)
			stopTog_reg <= ~stopTog_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Link rising edge: bit count, shift register, master acknowledge

	logic [3:0] bitCnt_reg;
	logic [7:0] shiftData_reg;
	logic       startAck_reg;
	logic       firstByte_reg;
	logic       masterNack_reg;
	logic       newStart;

	// Start toggle settles a full hold time before the first rising edge
	assign newStart = startTog_reg != startAck_reg;

	always_ff @(posedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			startAck_reg  <= 1'b0;
			bitCnt_reg    <= twsp_pkg::BIT_IDLE;
			firstByte_reg <= 1'b0;
		end else if (newStart) begin
			startAck_reg  <= startTog_reg;
			bitCnt_reg    <= twsp_pkg::BIT_FIRST;
			firstByte_reg <= 1'b1;
		end else if (bitCnt_reg == twsp_pkg::BIT_ACK) begin
			bitCnt_reg    <= twsp_pkg::BIT_FIRST;
			firstByte_reg <= 1'b0;
		end else if (bitCnt_reg != twsp_pkg::BIT_IDLE) begin
			bitCnt_reg    <= bitCnt_reg + twsp_pkg::BIT_STEP;
		end
	end

	always_ff @(posedge busClk or negedge rst_n) begin
		if (!rst_n)
			shiftData_reg <= twsp_pkg::BUFFER_RESET;
		else if (newStart || (bitCnt_reg != twsp_pkg::BIT_LAST_DATA &&
				bitCnt_reg != twsp_pkg::BIT_IDLE))
			shiftData_reg <= {shiftData_reg[6:0], busDataIn};
	end

	always_ff @(posedge busClk or negedge rst_n) begin
		if (!rst_n)
			masterNack_reg <= 1'b0;
		else if (bitCnt_reg == twsp_pkg::BIT_LAST_DATA && !newStart)
			masterNack_reg <= busDataIn;
	end

	////////////////////////////////////////////////////////////////////////
	// Link falling edge: byte decision

	twsp_pkg::twsp_phase_e phase_reg;
	twsp_pkg::twsp_phase_e phase_next;
	logic       cfgSlave7;
	logic       cfgSlave10;
	logic       bufFree;
	logic       hiMatch;
	logic       isEvent;
	logic       ackNow;
	logic       evAddr;
	logic       evRw;
	logic       evUa;
	logic       evTxDone;
	logic [7:0] ownAddress_reg;

	assign cfgSlave7  = linkCfgSync_reg[3];
	assign cfgSlave10 = linkCfgSync_reg[2];
	assign bufFree    = !linkCfgSync_reg[1] && !linkCfgSync_reg[0];
	// Own address only changes while the bus is idle or the clock is held low
	assign hiMatch    = shiftData_reg[7:1] == ownAddress_reg[7:1];

	logic tenLatched_reg;

	always_comb begin
		phase_next = twsp_pkg::PH_IDLE;
		isEvent    = 1'b0;
		ackNow     = 1'b0;
		evAddr     = 1'b0;
		evRw       = 1'b0;
		evUa       = 1'b0;
		evTxDone   = 1'b0;
		if (firstByte_reg) begin
			if (cfgSlave7 && hiMatch &&
					shiftData_reg[7:1] != twsp_pkg::GENERAL_CALL_ADDR) begin
				isEvent    = 1'b1;
				evAddr     = 1'b1;
				evRw       = shiftData_reg[0];
				ackNow     = bufFree;
				phase_next = shiftData_reg[0] ? twsp_pkg::PH_XMIT
					: twsp_pkg::PH_RECV;
			end else if (cfgSlave10 && hiMatch &&
					shiftData_reg[7:3] == twsp_pkg::TEN_BIT_PREFIX) begin
				if (!shiftData_reg[0]) begin
					isEvent    = 1'b1;
					evAddr     = 1'b1;
					evUa       = 1'b1;
					ackNow     = bufFree;
					phase_next = twsp_pkg::PH_ADDR2;
				end else if (tenLatched_reg) begin
					isEvent    = 1'b1;
					evAddr     = 1'b1;
					evRw       = 1'b1;
					ackNow     = bufFree;
					phase_next = twsp_pkg::PH_XMIT;
				end
			end
		end else begin
			case (phase_reg)
				twsp_pkg::PH_ADDR2: begin
					if (shiftData_reg == ownAddress_reg) begin
						isEvent    = 1'b1;
						evAddr     = 1'b1;
						evUa       = 1'b1;
						ackNow     = bufFree;
						phase_next = twsp_pkg::PH_RECV;
					end
				end
				twsp_pkg::PH_RECV: begin
					isEvent    = 1'b1;
					ackNow     = bufFree;
					phase_next = twsp_pkg::PH_RECV;
				end
				twsp_pkg::PH_XMIT: begin
					isEvent    = 1'b1;
					evTxDone   = 1'b1;
					phase_next = twsp_pkg::PH_XMIT;
				end
				default: phase_next = twsp_pkg::PH_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link falling edge: phase, pin drive and event hand-off

	logic       ackLow_reg;
	logic       txOn_reg;
	logic [2:0] txIdx_reg;
	logic [7:0] rxByte_reg;
	logic       pending_reg;
	logic       evAddr_reg;
	logic       evRw_reg;
	logic       evUa_reg;
	logic       evTxDone_reg;
	logic       evEnd_reg;
	logic       evStretch_reg;
	logic       evtTog_reg;
	logic       stretchReq_reg;
	logic       atEighth;
	logic       atNinth;
	logic       txContinue;

	assign atEighth   = bitCnt_reg == twsp_pkg::BIT_LAST_DATA;
	assign atNinth    = bitCnt_reg == twsp_pkg::BIT_ACK;
	assign txContinue = evTxDone_reg && !masterNack_reg;

	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg      <= twsp_pkg::PH_IDLE;
			tenLatched_reg <= 1'b0;
		end else if (!cfgSlave7 && !cfgSlave10) begin
			phase_reg      <= twsp_pkg::PH_IDLE;
			tenLatched_reg <= 1'b0;
		end else if (atEighth) begin
			phase_reg <= phase_next;
			if (phase_reg == twsp_pkg::PH_ADDR2)
				tenLatched_reg <= phase_next == twsp_pkg::PH_RECV;
			else if (firstByte_reg && !evRw)
				tenLatched_reg <= 1'b0;
		end else if (atNinth && evTxDone_reg && masterNack_reg) begin
			phase_reg <= twsp_pkg::PH_IDLE;
		end
	end

	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n)
			ackLow_reg <= 1'b0;
		else if (atEighth)
			ackLow_reg <= isEvent && ackNow;
		else
			ackLow_reg <= 1'b0;
	end

	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			txOn_reg  <= 1'b0;
			txIdx_reg <= 3'h0;
		end else if (firstByte_reg && !atNinth) begin
			txOn_reg  <= 1'b0;
		end else if (atNinth) begin
			txOn_reg  <= phase_reg == twsp_pkg::PH_XMIT &&
				(evRw_reg || txContinue);
			txIdx_reg <= 3'h0;
		end else if (atEighth) begin
			txOn_reg  <= 1'b0;
		end else if (txOn_reg) begin
			txIdx_reg <= bitCnt_reg[2:0];
		end
	end

	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			pending_reg    <= 1'b0;
			rxByte_reg     <= twsp_pkg::BUFFER_RESET;
			evAddr_reg     <= 1'b0;
			evRw_reg       <= 1'b0;
			evUa_reg       <= 1'b0;
			evTxDone_reg   <= 1'b0;
			evEnd_reg      <= 1'b0;
			evStretch_reg  <= 1'b0;
		end else if (atEighth) begin
			pending_reg    <= isEvent;
			rxByte_reg     <= shiftData_reg;
			evAddr_reg     <= evAddr;
			evRw_reg       <= evRw;
			evUa_reg       <= evUa;
			evTxDone_reg   <= evTxDone;
			evEnd_reg      <= 1'b0;
			evStretch_reg  <= evUa || evRw;
		end else if (atNinth && pending_reg) begin
			pending_reg    <= 1'b0;
			evEnd_reg      <= evTxDone_reg && masterNack_reg;
			if (txContinue)
				evStretch_reg <= 1'b1;
		end
	end

	// Toggles move at the ninth falling edge; fields stay put for a byte
	always_ff @(negedge busClk or negedge rst_n) begin
		if (!rst_n) begin
			evtTog_reg     <= 1'b0;
			stretchReq_reg <= 1'b0;
		end else if (atNinth && pending_reg) begin
			evtTog_reg <= ~evtTog_reg;
			if (evStretch_reg || txContinue)
				stretchReq_reg <= ~stretchReq_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core side: crossings of the link toggles

	logic [2:0] evtSync_reg;
	logic [2:0] startSync_reg;
	logic [2:0] stopSync_reg;
	logic       evtPulse;
	logic       startPulse;
	logic       stopPulse;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			evtSync_reg   <= 3'h0;
			startSync_reg <= 3'h0;
			stopSync_reg  <= 3'h0;
		end else begin
			evtSync_reg   <= {evtSync_reg[1:0], evtTog_reg};
			startSync_reg <= {startSync_reg[1:0], startTog_reg};
			stopSync_reg  <= {stopSync_reg[1:0], stopTog_reg};
		end
	end

	assign evtPulse   = evtSync_reg[2] != evtSync_reg[1];
	assign startPulse = startSync_reg[2] != startSync_reg[1];
	assign stopPulse  = stopSync_reg[2] != stopSync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Core side: software-visible state

	logic [7:0] transferBuffer_reg;
	logic       bufferFull_reg;
	logic       overflow_reg;
	logic       irqFlag_reg;
	logic       addrUpdate_reg;
	logic       rwStatus_reg;
	logic       clockRelease_reg;
	logic       stretchDone_reg;
	logic       startSeen_reg;
	logic       stopSeen_reg;
	logic       rxLoad;
	logic       rxOverflow;

	assign rxLoad     = evtPulse && !evTxDone_reg && !bufferFull_reg;
	assign rxOverflow = evtPulse && !evTxDone_reg && bufferFull_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			transferBuffer_reg <= twsp_pkg::BUFFER_RESET;
		else if (rxLoad)
			transferBuffer_reg <= rxByte_reg;
		else if (bufferWrite)
			transferBuffer_reg <= bufferWriteData;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bufferFull_reg <= 1'b0;
		else if (rxLoad || (bufferWrite && rwStatus_reg))
			bufferFull_reg <= 1'b1;
		else if (bufferRead || (evtPulse && evTxDone_reg))
			bufferFull_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			overflow_reg <= 1'b0;
		else if (rxOverflow)
			overflow_reg <= 1'b1;
		else if (overflowClear)
			overflow_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			irqFlag_reg <= 1'b0;
		else if (evtPulse || (ssIrqMode && (startPulse || stopPulse)))
			irqFlag_reg <= 1'b1;
		else if (irqFlagClear)
			irqFlag_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			addrUpdate_reg <= 1'b0;
		else if (evtPulse && evUa_reg)
			addrUpdate_reg <= 1'b1;
		else if (ownAddressWrite || (evtPulse && evEnd_reg))
			addrUpdate_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rwStatus_reg <= 1'b0;
		else if (evtPulse && evAddr_reg)
			rwStatus_reg <= evRw_reg;
		else if (evtPulse && evEnd_reg)
			rwStatus_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ownAddress_reg <= twsp_pkg::OWN_ADDR_RESET;
		else if (ownAddressWrite)
			ownAddress_reg <= ownAddressData;
	end

	// Hardware clear wins so a transmit never starts on stale data
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			clockRelease_reg <= twsp_pkg::CLK_RELEASE_RESET;
		else if (evtPulse && !evEnd_reg && (evRw_reg || evTxDone_reg))
			clockRelease_reg <= 1'b0;
		else if (clockReleaseWrite)
			clockRelease_reg <= clockReleaseData;
	end

	// Each stretch toggle rides with an event, so counting events suffices
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			stretchDone_reg <= 1'b0;
		else if (evtPulse && (evStretch_reg || (evTxDone_reg && !evEnd_reg)))
			stretchDone_reg <= ~stretchDone_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			startSeen_reg <= 1'b0;
			stopSeen_reg  <= 1'b0;
		end else if (!portEnable) begin
			startSeen_reg <= 1'b0;
			stopSeen_reg  <= 1'b0;
		end else if (startPulse) begin
			startSeen_reg <= 1'b1;
			stopSeen_reg  <= 1'b0;
		end else if (stopPulse) begin
			startSeen_reg <= 1'b0;
			stopSeen_reg  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and open-drain pins

	logic slaveOn;
	logic holdClk;
	logic txBit;

	assign slaveOn = slave7 || slave10;
	// Gap between the link edge and the core update is bridged by the XOR
	assign holdClk = (stretchReq_reg != stretchDone_reg) ||
		!clockRelease_reg || addrUpdate_reg;
	assign txBit   = transferBuffer_reg[twsp_pkg::TX_MSB - txIdx_reg];

	assign busClkOut    = 1'b0;
	assign busDataOut   = 1'b0;
	assign busClkOutEn  = twoWire && pinDirectionC[twsp_pkg::DIR_CLK] &&
		slaveOn && holdClk;
	assign busDataOutEn = twoWire && pinDirectionC[twsp_pkg::DIR_DATA] &&
		slaveOn && (ackLow_reg || (txOn_reg && !txBit));

	assign transferBuffer      = transferBuffer_reg;
	assign bufferFull          = bufferFull_reg;
	assign receiveOverflow     = overflow_reg;
	assign portIrqFlag         = irqFlag_reg;
	assign portIrq             = irqFlag_reg && irqEnable;
	assign addressUpdateNeeded = addrUpdate_reg;
	assign readWriteStatus     = rwStatus_reg;
	assign clockRelease        = clockRelease_reg;
	assign startDetected       = startSeen_reg;
	assign stopDetected        = stopSeen_reg;

endmodule : twsp_slave_port

`default_nettype wire
